// ---- pkg/ldfr_pkg.sv ----
// package: constants, types and helpers of the lock, fastlock and readback block
`default_nettype none
package ldfr_pkg;
   localparam int NREG = 16;
   localparam int IDX_W = 4;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h40;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h44;
   localparam logic [ADDR_W-1:0] OFF_STATE = 8'h48;
   localparam logic [IDX_W-1:0] R_FREQ = 4'h0;
   localparam logic [IDX_W-1:0] R_GAIN = 4'h1;
   localparam logic [IDX_W-1:0] R_FLTIME = 4'h2;
   localparam logic [IDX_W-1:0] R_LOCK = 4'h3;
   localparam logic [IDX_W-1:0] R_MISC = 4'h5;
   localparam logic [IDX_W-1:0] R_RDPTR = 4'h6;
   localparam int ID_BIT = 31;
   localparam int PTR_LSB = 5;
   localparam int GAIN_W = 5;
   localparam int NGAIN_LSB = 0;
   localparam int FGAIN_LSB = 8;
   localparam int FLT_W = 16;
   localparam int PE_W = 6;
   localparam int DLY_W = 6;
   localparam int TOL_W = 7;
   localparam int CNT_W = 8;
   localparam int TOL_LSB = 0;
   localparam int DLY_LSB = 8;
   localparam int ERR_LSB = 16;
   localparam int PASS_LSB = 24;
   localparam int PASS_SHIFT = 3;
   localparam int PASS_W = CNT_W + PASS_SHIFT;
   localparam int M_PD = 0;
   localparam int M_INTVCO = 1;
   localparam int M_BOVR = 2;
   localparam int M_BVAL = 3;
   localparam int M_COVR = 4;
   localparam int M_CVAL = 5;
   localparam int MUX_LSB = 8;
   localparam int MUX_W = 3;
   localparam logic [MUX_W-1:0] MUX_READBACK = 3'h6;
   localparam int AFLD_W = 4;
   localparam logic [AFLD_W-1:0] ADDR_ONES = 4'hf;
   localparam int IRQ_W = 3;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_UNLOCK = 1;
   localparam int IRQ_FLDONE = 2;
   localparam logic [31:0] RST_FREQ = 32'h8000_0000;
   localparam logic [31:0] RST_MISC = 32'h0000_0002;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int SYNC_W = 6;
   localparam int S_PD = 0;
   localparam int S_SCLK = 1;
   localparam int S_LE = 2;
   localparam int S_BUF = 3;
   localparam int S_CE = 4;
   localparam int S_VT = 5;

   typedef struct packed {
      logic [DLY_W-1:0] delay;
      logic [TOL_W-1:0] tol;
      logic [CNT_W-1:0] err_thr;
      logic [CNT_W-1:0] pass_thr;
   } lock_cfg_s;

   typedef enum logic {FL_IDLE, FL_ENGAGED} fl_state_e;

   function automatic logic bank_hit(input logic [ADDR_W-1:0] a);
      return a < ADDR_W'(NREG * 4);
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// ---- rtl/lock_detector.sv ----
// digital lock detector: pass and error counting of detector comparisons
`default_nettype none
module lock_detector
   import ldfr_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic            tick,
   input  wire logic            clear,
   input  wire logic            hold,
   input  wire logic [PE_W-1:0] phase_err,
   input  wire lock_cfg_s       cfg,
   output logic                 locked
);
   logic              locked_q, locked_d;
   logic [CNT_W-1:0]  err_q, err_d;
   logic [PASS_W-1:0] pass_q, pass_d;
   logic [TOL_W-1:0]  sum;
   logic              is_err;
   logic [CNT_W:0]    err_inc;
   logic [PASS_W:0]   pass_inc;
   logic [PASS_W:0]   pass_goal;

   assign locked = locked_q;

   always_comb begin
      sum = TOL_W'(phase_err) + TOL_W'(cfg.delay);
      is_err = sum > cfg.tol;
      err_inc = {1'b0, err_q} + 1'b1;
      pass_inc = {1'b0, pass_q} + 1'b1;
      pass_goal = {1'b0, cfg.pass_thr, {PASS_SHIFT{1'b0}}};
      locked_d = locked_q;
      err_d = err_q;
      pass_d = pass_q;
      if (clear) begin
         locked_d = 1'b0;
         err_d = '0;
         pass_d = '0;
      end else if (tick && !hold) begin
         if (is_err) begin
            pass_d = '0;
            if (err_inc >= {1'b0, cfg.err_thr}) begin
               locked_d = 1'b0;
               err_d = '0;
            end else begin
               err_d = err_inc[CNT_W-1:0];
            end
         end else if (pass_inc >= pass_goal) begin
            locked_d = 1'b1;
            err_d = '0;
            pass_d = '0;
         end else begin
            pass_d = pass_inc[PASS_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         locked_q <= 1'b0;
         err_q <= '0;
         pass_q <= '0;
      end else begin
         locked_q <= locked_d;
         err_q <= err_d;
         pass_q <= pass_d;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ld_clear_a: assert property (clear |=> !locked_q && err_q == '0 && pass_q == '0)
      else $error("detector not cleared on restart");
   ld_unlock_a: assert property (!clear && tick && !hold && is_err
      && err_inc >= {1'b0, cfg.err_thr} |=> !locked_q)
      else $error("unlock not declared at error count");
   ld_lock_a: assert property (!clear && tick && !hold && !is_err
      && pass_inc >= pass_goal |=> locked_q && err_q == '0)
      else $error("lock not declared at pass count");
endmodule
`default_nettype wire

// ---- rtl/readback_shifter.sv ----
// serial readback shifter: loads on latch rise, advances on clock rise
`default_nettype none
module readback_shifter
   import ldfr_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        le_rise,
   input  wire logic        sclk_rise,
   input  wire logic [31:0] word,
   output logic             rb_bit
);
   logic [31:0] sh_q, sh_d;

   assign rb_bit = sh_q[31];

   always_comb begin
      sh_d = sh_q;
      if (le_rise) begin
         sh_d = {word[31:AFLD_W], ADDR_ONES};
      end else if (sclk_rise) begin
         sh_d = {sh_q[30:0], 1'b1};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sh_q <= '1;
      end else begin
         sh_q <= sh_d;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence load_s;
      le_rise ##1 sh_q[AFLD_W-1:0] == ADDR_ONES;
   endsequence
   rb_load_a: assert property (le_rise |-> load_s)
      else $error("readback word not loaded with ones address");
   rb_shift_a: assert property (!le_rise && sclk_rise |=> rb_bit == $past(sh_q[30]))
      else $error("readback did not advance on clock rise");
endmodule
`default_nettype wire

// ---- rtl/lock_detect_fastlock_readback.sv ----
// top: register bank, fastlock timer, lock indication and readback selection
`default_nettype none
module lock_detect_fastlock_readback
   import ldfr_pkg::*;
#(
   parameter logic [31:0] PART_ID_BASE = 32'h0000_0c00 // arbitrary value
)(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              pd_clk_pin,
   input  wire logic              sclk_pin,
   input  wire logic              le_pin,
   input  wire logic              buffer_enable_pin,
   input  wire logic              chip_enable_pin,
   input  wire logic              vtune_in_window,
   input  wire logic [PE_W-1:0]   phase_err,
   output logic                   fastlock_switch_pin_o,
   output logic                   fastlock_switch_pin_oe,
   output logic [GAIN_W-1:0]      pump_gain,
   output logic                   buffer_enable_eff,
   output logic                   chip_enable_eff,
   output logic                   lock_indicator_pin,
   output logic                   muxed_output_pin,
   output logic                   irq
);
   logic [SYNC_W-1:0] s1_q, s2_q, s3_q, rise;
   logic [31:0]       bank_q [NREG];
   logic [31:0]       bank_d [NREG];
   logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic [31:0]       w_data_q, w_data_d;
   logic [3:0]        w_strb_q, w_strb_d;
   logic              awready_q, awready_d, wready_q, wready_d;
   logic              bvalid_q, bvalid_d, arready_q, arready_d;
   logic              rvalid_q, rvalid_d;
   logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0]       rdata_q, rdata_d;
   logic [IRQ_W-1:0]  status_q, status_d, mask_q, mask_d, ev, clr;
   logic              irq_q, irq_d, do_write, freq_wr;
   logic [IDX_W-1:0]  widx;
   fl_state_e         fl_state_q, fl_state_d;
   logic [FLT_W-1:0]  fl_cnt_q, fl_cnt_d;
   logic              fl_oe_q, fl_oe_d, fl_done;
   logic [GAIN_W-1:0] gain_q, gain_d;
   logic              buf_q, buf_d, ce_q, ce_d;
   logic              lock_q, lock_d, mux_q, mux_d, dld_prev_q;
   logic              dld_locked, vt_ok, rb_bit;
   logic [31:0]       misc, rb_word;
   lock_cfg_s         cfg;

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign fastlock_switch_pin_o = 1'b0;
   assign fastlock_switch_pin_oe = fl_oe_q;
   assign pump_gain = gain_q;
   assign buffer_enable_eff = buf_q;
   assign chip_enable_eff = ce_q;
   assign lock_indicator_pin = lock_q;
   assign muxed_output_pin = mux_q;
   assign irq = irq_q;

   // pin synchroniser, third stage only for edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= {vtune_in_window, chip_enable_pin, buffer_enable_pin,
                  le_pin, sclk_pin, pd_clk_pin};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign rise = s2_q & ~s3_q;

   assign misc = bank_q[R_MISC];
   assign cfg = '{delay: bank_q[R_LOCK][DLY_LSB +: DLY_W],
                  tol: bank_q[R_LOCK][TOL_LSB +: TOL_W],
                  err_thr: bank_q[R_LOCK][ERR_LSB +: CNT_W],
                  pass_thr: bank_q[R_LOCK][PASS_LSB +: CNT_W]};

   // register bus slave
   always_comb begin
      aw_have_d = aw_have_q;
      aw_addr_d = aw_addr_q;
      w_have_d = w_have_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      mask_d = mask_q;
      clr = '0;
      freq_wr = 1'b0;
      widx = aw_addr_q[IDX_W+1:2];
      for (int i = 0; i < NREG; i++) begin
         bank_d[i] = bank_q[i];
      end
      if (awvalid && awready_q) begin
         aw_have_d = 1'b1;
         aw_addr_d = awaddr;
      end
      if (wvalid && wready_q) begin
         w_have_d = 1'b1;
         w_data_d = wdata;
         w_strb_d = wstrb;
      end
      do_write = aw_have_q && w_have_q && !bvalid_q;
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         if (bank_hit(aw_addr_q)) begin
            bank_d[widx] = apply_strb(bank_q[widx], w_data_q, w_strb_q);
            freq_wr = widx == R_FREQ;
         end else if (aw_addr_q == OFF_MASK) begin
            mask_d = IRQ_W'(apply_strb(32'(mask_q), w_data_q, w_strb_q));
         end else if (aw_addr_q == OFF_STATUS) begin
            clr = w_strb_q[0] ? w_data_q[IRQ_W-1:0] : '0;
         end else begin
            bresp_d = RESP_SLVERR;
         end
      end else if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         if (bank_hit(araddr)) begin
            rdata_d = bank_q[araddr[IDX_W+1:2]];
         end else if (araddr == OFF_STATUS) begin
            rdata_d = 32'(status_q);
         end else if (araddr == OFF_MASK) begin
            rdata_d = 32'(mask_q);
         end else if (araddr == OFF_STATE) begin
            rdata_d = {22'h0, gain_q, vt_ok, dld_locked, fl_oe_q, lock_q, irq_q};
         end else begin
            rdata_d = '0;
            rresp_d = RESP_SLVERR;
         end
      end else if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      awready_d = !aw_have_d && !bvalid_d;
      wready_d = !w_have_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NREG; i++) begin
            bank_q[i] <= (i == int'(R_FREQ)) ? RST_FREQ :
                         (i == int'(R_MISC)) ? RST_MISC : '0;
         end
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
         mask_q <= '0;
      end else begin
         for (int i = 0; i < NREG; i++) begin
            bank_q[i] <= bank_d[i];
         end
         aw_have_q <= aw_have_d;
         aw_addr_q <= aw_addr_d;
         w_have_q <= w_have_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         mask_q <= mask_d;
      end
   end

   // fastlock timer
   always_comb begin
      fl_state_d = fl_state_q;
      fl_cnt_d = fl_cnt_q;
      fl_done = 1'b0;
      if (freq_wr) begin
         fl_cnt_d = bank_q[R_FLTIME][FLT_W-1:0];
         fl_state_d = (fl_cnt_d != '0) ? FL_ENGAGED : FL_IDLE;
      end else begin
         case (fl_state_q)
            FL_ENGAGED: begin
               if (rise[S_PD]) begin
                  fl_cnt_d = fl_cnt_q - 1'b1;
                  if (fl_cnt_q == FLT_W'(1)) begin
                     fl_state_d = FL_IDLE;
                     fl_done = 1'b1;
                  end
               end
            end
            FL_IDLE: begin
               fl_cnt_d = '0;
            end
            default: begin
               fl_state_d = FL_IDLE;
            end
         endcase
      end
      fl_oe_d = fl_state_d == FL_ENGAGED;
      gain_d = fl_oe_d ? bank_q[R_GAIN][FGAIN_LSB +: GAIN_W]
                       : bank_q[R_GAIN][NGAIN_LSB +: GAIN_W];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fl_state_q <= FL_IDLE;
         fl_cnt_q <= '0;
         fl_oe_q <= 1'b0;
         gain_q <= '0;
      end else begin
         fl_state_q <= fl_state_d;
         fl_cnt_q <= fl_cnt_d;
         fl_oe_q <= fl_oe_d;
         gain_q <= gain_d;
      end
   end

   lock_detector u_dld (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .tick      (rise[S_PD]),
      .clear     (freq_wr),
      .hold      (misc[M_PD]),
      .phase_err (phase_err),
      .cfg       (cfg),
      .locked    (dld_locked)
   );

   // readback word and pin outputs
   always_comb begin
      rb_word = bank_q[R_FREQ][ID_BIT]
              ? {PART_ID_BASE[31:6], s2_q[S_BUF], s2_q[S_CE], 4'h0}
              : bank_q[bank_q[R_RDPTR][PTR_LSB +: IDX_W]];
      vt_ok = !misc[M_INTVCO] || s2_q[S_VT];
      lock_d = dld_locked && vt_ok;
      mux_d = (misc[MUX_LSB +: MUX_W] == MUX_READBACK) ? rb_bit : lock_d;
      buf_d = misc[M_BOVR] ? misc[M_BVAL] : s2_q[S_BUF];
      ce_d = misc[M_COVR] ? misc[M_CVAL] : s2_q[S_CE];
      ev = '0;
      ev[IRQ_LOCK] = dld_locked && !dld_prev_q;
      ev[IRQ_UNLOCK] = !dld_locked && dld_prev_q;
      ev[IRQ_FLDONE] = fl_done;
      status_d = (status_q & ~clr) | ev;
      irq_d = |(status_d & mask_q);
   end

   readback_shifter u_rb (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .le_rise   (rise[S_LE]),
      .sclk_rise (rise[S_SCLK]),
      .word      (rb_word),
      .rb_bit    (rb_bit)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_q <= 1'b0;
         mux_q <= 1'b0;
         buf_q <= 1'b0;
         ce_q <= 1'b0;
         status_q <= '0;
         irq_q <= 1'b0;
         dld_prev_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
         mux_q <= mux_d;
         buf_q <= buf_d;
         ce_q <= ce_d;
         status_q <= status_d;
         irq_q <= irq_d;
         dld_prev_q <= dld_locked;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   fl_pin_a: assert property ($rose(fl_oe_q) |-> $past(freq_wr))
      else $error("switch pin driven without frequency change");
   fl_gain_a: assert property (fl_oe_q |-> gain_q == $past(bank_q[R_GAIN][FGAIN_LSB +: GAIN_W]))
      else $error("fast gain not applied in fastlock");
   fl_load_a: assert property (freq_wr && bank_q[R_FLTIME][FLT_W-1:0] != '0
      |=> fl_state_q == FL_ENGAGED && fl_cnt_q == $past(bank_q[R_FLTIME][FLT_W-1:0]))
      else $error("timeout not loaded on frequency change");
   fl_end_a: assert property (fl_state_q == FL_ENGAGED && !freq_wr && rise[S_PD]
      && fl_cnt_q == FLT_W'(1) |=> fl_state_q == FL_IDLE && !fastlock_switch_pin_oe)
      else $error("fastlock did not end after count");
   vtune_lock_a: assert property (misc[M_INTVCO] && !s2_q[S_VT] |=> !lock_q)
      else $error("lock shown with tuning voltage out of window");
   status_set_a: assert property (ev[IRQ_FLDONE] |=> status_q[IRQ_FLDONE])
      else $error("event lost against clear");
endmodule
`default_nettype wire

// ---- testbench/serial_host_model.sv ----
// host side of the serial readback link
`default_nettype none
module serial_host_model (
   output logic      sclk,
   output logic      le,
   input  wire logic rb
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      le = 1'b0;
   end
   task automatic read_word(output logic [31:0] w);
      #3 le = 1'b1;
      #64 w[31] = rb;
      // late sampling covers sync delay
      for (int i = 30; i >= 0; i--) begin
         sclk = 1'b1;
         #32 sclk = 1'b0;
         #32 w[i] = rb;
      end
      le = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- testbench/test_lock_detect_fastlock_readback.sv ----
// bench for fastlock, lock detect and readback
`default_nettype none
module test_lock_detect_fastlock_readback
   import ldfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ID_BASE = 32'h0000_0c00; // arbitrary value
   logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready, pd_clk_pin, sclk_pin, le_pin;
   logic              buffer_enable_pin, chip_enable_pin, vtune_in_window, irq;
   logic              fastlock_switch_pin_o, fastlock_switch_pin_oe, buffer_enable_eff;
   logic              chip_enable_eff, lock_indicator_pin, muxed_output_pin;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, rd_data, w;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, resp, pd_div;
   logic [PE_W-1:0]   phase_err;
   logic [GAIN_W-1:0] pump_gain;
   int                n_mismatch, checked;

   lock_detect_fastlock_readback #(.PART_ID_BASE(ID_BASE)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pd_clk_pin(pd_clk_pin), .sclk_pin(sclk_pin), .le_pin(le_pin),
      .buffer_enable_pin(buffer_enable_pin), .chip_enable_pin(chip_enable_pin),
      .vtune_in_window(vtune_in_window), .phase_err(phase_err),
      .fastlock_switch_pin_o(fastlock_switch_pin_o),
      .fastlock_switch_pin_oe(fastlock_switch_pin_oe), .pump_gain(pump_gain),
      .buffer_enable_eff(buffer_enable_eff), .chip_enable_eff(chip_enable_eff),
      .lock_indicator_pin(lock_indicator_pin), .muxed_output_pin(muxed_output_pin),
      .irq(irq)
   );
   serial_host_model host (.sclk(sclk_pin), .le(le_pin), .rb(muxed_output_pin));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      pd_div <= (pd_div == 2'd2) ? 2'd0 : pd_div + 2'd1;
      if (pd_div == 2'd2) pd_clk_pin <= ~pd_clk_pin;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 100);
      resp = bresp;
      bready <= 1'b0;
      if (n >= 100) n_mismatch++;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready) && n < 100);
      rd_data = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 100) n_mismatch++;
   endtask

   task automatic t_regs;
      rd(8'h00);
      chk(rd_data, RST_FREQ);
      rd(8'h14);
      chk(rd_data, RST_MISC);
      chk(resp, RESP_OKAY);
      rd(8'h4c);
      chk({resp, rd_data}, {RESP_SLVERR, 32'h0});
      wr(8'h4c, 32'h1);
      chk(resp, RESP_SLVERR);
      rd(OFF_STATE);
      chk(rd_data, 32'h0000_001a);
      chk(muxed_output_pin, 1'b1);
   endtask

   task automatic t_ident;
      wr(8'h14, 32'h0000_0602);
      for (int i = 0; i < 4; i++) begin
         @(posedge aclk);
         buffer_enable_pin <= i[1];
         chip_enable_pin <= i[0];
         cyc(6);
         chk(buffer_enable_eff, i[1]);
         host.read_word(w);
         chk(w, {ID_BASE[31:6], i[1], i[0], 4'hf});
      end
      wr(8'h14, 32'h0000_0616);
      cyc(4);
      chk({buffer_enable_eff, chip_enable_eff}, 2'b00);
      wr(8'h14, 32'h0000_0602);
   endtask

   task automatic t_fastlock;
      int n;
      wr(OFF_MASK, 32'h4);
      wr(8'h04, 32'h0000_1f03);
      wr(8'h08, 32'h0000_0014);
      wr(8'h00, 32'h0);
      cyc(2);
      chk({fastlock_switch_pin_oe, fastlock_switch_pin_o}, 2'b10);
      chk(pump_gain, 5'h1f);
      cyc(60);
      wr(8'h00, 32'h0);
      cyc(2);
      n = 2;
      while (fastlock_switch_pin_oe === 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      chk(n >= 108 && n <= 130, 1'b1);
      cyc(2);
      chk(pump_gain, 5'h03);
      chk(irq, 1'b1);
      rd(OFF_STATUS);
      chk(rd_data & 32'h4, 32'h4);
      wr(OFF_STATUS, 32'h4);
      cyc(3);
      chk(irq, 1'b0);
   endtask

   task automatic t_lock;
      wr(8'h0c, 32'h0203_0414);
      phase_err <= 6'd16;
      cyc(200);
      chk(lock_indicator_pin, 1'b1);
      wr(8'h00, 32'h0);
      cyc(3);
      chk(lock_indicator_pin, 1'b0);
      cyc(200);
      chk(lock_indicator_pin, 1'b1);
      phase_err <= 6'd17;
      cyc(9);
      chk(lock_indicator_pin, 1'b1);
      cyc(30);
      chk(lock_indicator_pin, 1'b0);
      phase_err <= 6'd10;
      cyc(200);
      vtune_in_window <= 1'b0;
      cyc(8);
      chk(lock_indicator_pin, 1'b0);
      vtune_in_window <= 1'b1;
      wr(8'h14, 32'h0000_0603);
      phase_err <= 6'd17;
      cyc(60);
      chk(lock_indicator_pin, 1'b1);
      phase_err <= 6'd10;
      wr(8'h14, 32'h0000_0600);
      vtune_in_window <= 1'b0;
      cyc(8);
      chk(lock_indicator_pin, 1'b1);
      vtune_in_window <= 1'b1;
      wr(8'h14, 32'h0000_0602);
   endtask

   task automatic t_readback;
      wr(8'h00, 32'h0);
      wr(8'h18, 32'h0000_0060);
      host.read_word(w);
      chk(w, 32'h0203_041f);
      wr(8'h18, 32'h0000_00c0);
      host.read_word(w);
      chk(w, 32'h0000_00cf);
   endtask

   task automatic print_verdict;
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
      {awaddr, araddr, wdata, wstrb, phase_err, pd_div} = '0;
      {pd_clk_pin, buffer_enable_pin, chip_enable_pin} = '0;
      vtune_in_window = 1'b1;
      cyc(16);
      aresetn <= 1'b1;
      cyc(2);
      t_regs;
      t_ident;
      t_fastlock;
      t_lock;
      t_readback;
      print_verdict;
   end

   initial begin
      #200us;
      n_mismatch++;
      print_verdict;
   end
endmodule
`default_nettype wire
